// ==== hdl/dar_device.sv ====
// Converter end: conversion framing, result shifting and offset calibration.
`timescale 1ns/10ps
module dar_device
    import dar_pkg::*;
(
    // Clock and reset.
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    // Serial link.
    dar_link_if.dev                LINK,
    // Converter codes and configuration.
    input  wire logic [RES_W-1:0]  RAW_A,
    input  wire logic [RES_W-1:0]  RAW_B,
    input  wire logic [GAIN_W-1:0] GAIN_SEL,
    input  wire logic [RES_W-1:0]  CTRL_WORD,
    input  wire logic              CTRL_WR,
    // Status.
    output logic                   HOLD,
    output logic                   INPUTS_SHORTED,
    output logic                   CAL_DONE,
    output logic                   CAL_INACCURATE,
    output logic                   RESULT_CORRUPT,
    output logic                   GAIN_STALE,
    output logic [RES_W-1:0]       OFFSET_A,
    output logic [RES_W-1:0]       OFFSET_B
);

    // Subtracts a stored offset, saturating to the signed result range.
    function automatic logic [RES_W-1:0] sub_sat(
        input logic [RES_W-1:0] raw,
        input logic [RES_W-1:0] off
    );
        logic signed [RES_W:0] d;
        d = $signed({raw[RES_W-1], raw}) - $signed({off[RES_W-1], off});
        if (d > SAT_HI) begin
            sub_sat = SAT_HI[RES_W-1:0];
        end else if (d < SAT_LO) begin
            sub_sat = SAT_LO[RES_W-1:0];
        end else begin
            sub_sat = d[RES_W-1:0];
        end
    endfunction

    // Limits a measured offset to the correctable range.
    function automatic logic [RES_W-1:0] clamp_off(
        input logic [RES_W-1:0] code
    );
        if ($signed(code) > OFF_HI) begin
            clamp_off = OFF_HI;
        end else if ($signed(code) < OFF_LO) begin
            clamp_off = OFF_LO;
        end else begin
            clamp_off = code;
        end
    endfunction

    dar_dev_type       state_r;
    dar_dev_type       state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [CNT_W-1:0]  cnt_inc;
    logic              sclk_q_r;
    logic              cs_q_r;
    logic              req_q_r;
    logic              oe_n_r;
    logic              oe_n_nxt;
    logic [RES_W-1:0]  shift_a_r;
    logic [RES_W-1:0]  shift_a_nxt;
    logic [RES_W-1:0]  shift_b_r;
    logic [RES_W-1:0]  shift_b_nxt;
    logic [RES_W-1:0]  other_a_r;
    logic [RES_W-1:0]  other_a_nxt;
    logic [RES_W-1:0]  other_b_r;
    logic [RES_W-1:0]  other_b_nxt;
    logic [RES_W-1:0]  samp_a_r;
    logic [RES_W-1:0]  samp_a_nxt;
    logic [RES_W-1:0]  samp_b_r;
    logic [RES_W-1:0]  samp_b_nxt;
    logic [RES_W-1:0]  off_a_r;
    logic [RES_W-1:0]  off_a_nxt;
    logic [RES_W-1:0]  off_b_r;
    logic [RES_W-1:0]  off_b_nxt;
    logic [GAIN_W-1:0] gain_cal_r;
    logic [GAIN_W-1:0] gain_cal_nxt;
    logic [3:0]        lead_r;
    logic [3:0]        lead_nxt;
    logic              hold_r;
    logic              hold_nxt;
    logic              short_r;
    logic              short_nxt;
    logic              cal_run_r;
    logic              cal_run_nxt;
    logic              pend_r;
    logic              pend_nxt;
    logic              spoil_r;
    logic              spoil_nxt;
    logic              done_r;
    logic              done_nxt;
    logic              inacc_r;
    logic              inacc_nxt;
    logic              corrupt_r;
    logic              corrupt_nxt;
    logic              stale_r;
    logic              stale_nxt;
    logic              sclk_fall;
    logic              cs_fall;
    logic              cs_rise;
    logic              ctrl_cal;

    // Edge detection on the synchronous link inputs.
    assign sclk_fall = sclk_q_r & ~LINK.sclk;
    assign cs_fall   = cs_q_r & ~LINK.cs_n;
    assign cs_rise   = ~cs_q_r & LINK.cs_n;
    assign ctrl_cal  = CTRL_WR & CTRL_WORD[CTRL_CAL_BIT];
    assign cnt_inc   = cnt_r + CNT_ONE;

    // Next-state logic for framing, shifting and calibration.
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        oe_n_nxt    = oe_n_r;
        shift_a_nxt = shift_a_r;
        shift_b_nxt = shift_b_r;
        other_a_nxt = other_a_r;
        other_b_nxt = other_b_r;
        samp_a_nxt  = samp_a_r;
        samp_b_nxt  = samp_b_r;
        off_a_nxt   = off_a_r;
        off_b_nxt   = off_b_r;
        gain_cal_nxt = gain_cal_r;
        hold_nxt    = hold_r;
        short_nxt   = short_r;
        cal_run_nxt = cal_run_r;
        inacc_nxt   = inacc_r;
        corrupt_nxt = corrupt_r;
        done_nxt    = 1'b0;
        // A control write with the calibration bit set latches a pending calibration.
        pend_nxt    = pend_r | ctrl_cal;
        // The old offset stays applied; only a flag shows the change.
        stale_nxt   = (GAIN_SEL != gain_cal_r);
        // Count how long the request has stood before select falls.
        lead_nxt    = lead_r;
        if (!LINK.cal_req) begin
            lead_nxt = 4'h0;
        end else if (lead_r < CAL_LEAD_CYC) begin
            lead_nxt = lead_r + 4'h1;
        end
        // A request raised mid-conversion spoils that conversion.
        spoil_nxt = spoil_r;
        if (state_r == DEV_CONV &&
            ((LINK.cal_req & ~req_q_r) | ctrl_cal)) begin
            spoil_nxt = 1'b1;
        end
        if (cs_rise) begin
            state_nxt = DEV_IDLE;
            oe_n_nxt  = 1'b1;
            hold_nxt  = 1'b0;
            short_nxt = 1'b0;
        end else if (cs_fall) begin
            // A clock fall in this same cycle is not counted.
            state_nxt  = DEV_CONV;
            cnt_nxt    = CNT_ZERO;
            hold_nxt   = 1'b1;
            samp_a_nxt = RAW_A;
            samp_b_nxt = RAW_B;
            oe_n_nxt   = 1'b1;
            cal_run_nxt = LINK.cal_req | pend_r | ctrl_cal;
            short_nxt  = LINK.cal_req | pend_r | ctrl_cal;
            pend_nxt   = 1'b0;
            inacc_nxt  = LINK.cal_req & (lead_r < CAL_LEAD_CYC);
            spoil_nxt  = 1'b0;
        end else if (sclk_fall && state_r != DEV_IDLE) begin
            cnt_nxt = cnt_inc;
            if (cnt_inc == FALL_MSB) begin
                // Conversion ends: track again and present both MSBs.
                state_nxt   = DEV_SHIFT;
                hold_nxt    = 1'b0;
                short_nxt   = 1'b0;
                oe_n_nxt    = 1'b0;
                shift_a_nxt = sub_sat(samp_a_r, off_a_r);
                shift_b_nxt = sub_sat(samp_b_r, off_b_r);
                other_a_nxt = sub_sat(samp_b_r, off_b_r);
                other_b_nxt = sub_sat(samp_a_r, off_a_r);
                corrupt_nxt = spoil_r;
                if (cal_run_r) begin
                    off_a_nxt    = clamp_off(samp_a_r);
                    off_b_nxt    = clamp_off(samp_b_r);
                    gain_cal_nxt = GAIN_SEL;
                    done_nxt     = 1'b1;
                    cal_run_nxt  = 1'b0;
                end
            end else if (cnt_inc == FALL_SECOND) begin
                // Swap in the other converter's word on each line.
                shift_a_nxt = other_a_r;
                shift_b_nxt = other_b_r;
            end else if (cnt_inc == FALL_OFF) begin
                state_nxt = DEV_IDLE;
                oe_n_nxt  = 1'b1;
            end else if (state_r == DEV_SHIFT) begin
                shift_a_nxt = {shift_a_r[RES_W-2:0], 1'b0};
                shift_b_nxt = {shift_b_r[RES_W-2:0], 1'b0};
            end
        end
    end

    // Registers, cleared by the synchronous reset.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_r    <= DEV_IDLE;
            cnt_r      <= CNT_ZERO;
            sclk_q_r   <= 1'b1;
            cs_q_r     <= 1'b1;
            req_q_r    <= 1'b0;
            oe_n_r     <= 1'b1;
            shift_a_r  <= RES_ZERO;
            shift_b_r  <= RES_ZERO;
            other_a_r  <= RES_ZERO;
            other_b_r  <= RES_ZERO;
            samp_a_r   <= RES_ZERO;
            samp_b_r   <= RES_ZERO;
            off_a_r    <= RES_ZERO;
            off_b_r    <= RES_ZERO;
            gain_cal_r <= 4'h0;
            lead_r     <= 4'h0;
            hold_r     <= 1'b0;
            short_r    <= 1'b0;
            cal_run_r  <= 1'b0;
            pend_r     <= 1'b0;
            spoil_r    <= 1'b0;
            done_r     <= 1'b0;
            inacc_r    <= 1'b0;
            corrupt_r  <= 1'b0;
            stale_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            sclk_q_r   <= LINK.sclk;
            cs_q_r     <= LINK.cs_n;
            req_q_r    <= LINK.cal_req;
            oe_n_r     <= oe_n_nxt;
            shift_a_r  <= shift_a_nxt;
            shift_b_r  <= shift_b_nxt;
            other_a_r  <= other_a_nxt;
            other_b_r  <= other_b_nxt;
            samp_a_r   <= samp_a_nxt;
            samp_b_r   <= samp_b_nxt;
            off_a_r    <= off_a_nxt;
            off_b_r    <= off_b_nxt;
            gain_cal_r <= gain_cal_nxt;
            lead_r     <= lead_nxt;
            hold_r     <= hold_nxt;
            short_r    <= short_nxt;
            cal_run_r  <= cal_run_nxt;
            pend_r     <= pend_nxt;
            spoil_r    <= spoil_nxt;
            done_r     <= done_nxt;
            inacc_r    <= inacc_nxt;
            corrupt_r  <= corrupt_nxt;
            stale_r    <= stale_nxt;
        end
    end

    // Line drive comes straight from the shift register MSBs.
    assign LINK.a_o    = shift_a_r[RES_W-1];
    assign LINK.b_o    = shift_b_r[RES_W-1];
    assign LINK.a_oe_n = oe_n_r;
    assign LINK.b_oe_n = oe_n_r;

    // Status outputs.
    assign HOLD           = hold_r;
    assign INPUTS_SHORTED = short_r;
    assign CAL_DONE       = done_r;
    assign CAL_INACCURATE = inacc_r;
    assign RESULT_CORRUPT = corrupt_r;
    assign GAIN_STALE     = stale_r;
    assign OFFSET_A       = off_a_r;
    assign OFFSET_B       = off_b_r;

endmodule

// ==== hdl/dar_host.sv ====
// Host end: frames conversions, makes the serial clock, collects results.
`timescale 1ns/10ps
module dar_host
    import dar_pkg::*;
(
    // Clock and reset.
    input  wire logic             CORE_CLK,
    input  wire logic             RST_N,
    // Serial link.
    dar_link_if.host              LINK,
    // User requests.
    input  wire logic             START,
    input  wire logic             ONE_LINE,
    input  wire logic             CAL_WANT,
    // Results.
    output logic                  BUSY,
    output logic [RES_W-1:0]      WORD_A,
    output logic [RES_W-1:0]      WORD_B,
    output logic                  WORD_VALID
);

    dar_host_type     state_r;
    dar_host_type     state_nxt;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    logic [CNT_W-1:0] edges_r;
    logic [CNT_W-1:0] edges_nxt;
    logic [CNT_W-1:0] e;
    logic             sclk_r;
    logic             sclk_nxt;
    logic             cs_n_r;
    logic             cs_n_nxt;
    logic             cal_r;
    logic             cal_nxt;
    logic             one_r;
    logic             one_nxt;
    logic [RES_W-1:0] acc_a_r;
    logic [RES_W-1:0] acc_a_nxt;
    logic [RES_W-1:0] acc_b_r;
    logic [RES_W-1:0] acc_b_nxt;
    logic [RES_W-1:0] word_a_r;
    logic [RES_W-1:0] word_a_nxt;
    logic [RES_W-1:0] word_b_r;
    logic [RES_W-1:0] word_b_nxt;
    logic             valid_r;
    logic             valid_nxt;
    logic             busy_r;
    logic             busy_nxt;

    assign e = edges_r + CNT_ONE;

    // Next-state logic for the frame, divider and sampling.
    always_comb begin
        state_nxt  = state_r;
        div_nxt    = div_r;
        edges_nxt  = edges_r;
        sclk_nxt   = sclk_r;
        cs_n_nxt   = cs_n_r;
        one_nxt    = one_r;
        acc_a_nxt  = acc_a_r;
        acc_b_nxt  = acc_b_r;
        word_a_nxt = word_a_r;
        word_b_nxt = word_b_r;
        valid_nxt  = 1'b0;
        // The request pin changes only while select is high.
        cal_nxt    = cs_n_r ? CAL_WANT : cal_r;
        case (state_r)
            H_IDLE: begin
                sclk_nxt = 1'b1;
                if (START) begin
                    state_nxt = H_FRAME;
                    cs_n_nxt  = 1'b0;
                    div_nxt   = 2'h0;
                    edges_nxt = CNT_ZERO;
                    one_nxt   = ONE_LINE;
                end
            end
            H_FRAME: begin
                if (div_r == SCLK_HALF_M1) begin
                    div_nxt  = 2'h0;
                    sclk_nxt = ~sclk_r;
                    if (sclk_r) begin
                        edges_nxt = e;
                        // Slow clock: sample as each fall is made.
                        if (e >= HOST_FIRST && e <= HOST_LAST) begin
                            acc_a_nxt = {acc_a_r[RES_W-2:0],
                                         LINK.result_line_a};
                            if (!one_r) begin
                                acc_b_nxt = {acc_b_r[RES_W-2:0],
                                             LINK.result_line_b};
                            end
                        end else if (one_r && e <= HOST_LAST2) begin
                            acc_b_nxt = {acc_b_r[RES_W-2:0],
                                         LINK.result_line_a};
                        end
                        if (e == (one_r ? HOST_LAST2 : HOST_LAST)) begin
                            state_nxt = H_GAP;
                        end
                    end
                end else begin
                    div_nxt = div_r + 2'h1;
                end
            end
            H_GAP: begin
                state_nxt  = H_IDLE;
                cs_n_nxt   = 1'b1;
                sclk_nxt   = 1'b1;
                word_a_nxt = acc_a_r;
                word_b_nxt = acc_b_r;
                valid_nxt  = 1'b1;
            end
            default: begin
                state_nxt = H_IDLE;
            end
        endcase
        // Busy follows the next state so it is ready with the state flop.
        busy_nxt = (state_nxt != H_IDLE);
    end

    // Registers, cleared by the synchronous reset.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_r  <= H_IDLE;
            div_r    <= 2'h0;
            edges_r  <= CNT_ZERO;
            sclk_r   <= 1'b1;
            cs_n_r   <= 1'b1;
            cal_r    <= 1'b0;
            one_r    <= 1'b0;
            acc_a_r  <= RES_ZERO;
            acc_b_r  <= RES_ZERO;
            word_a_r <= RES_ZERO;
            word_b_r <= RES_ZERO;
            valid_r  <= 1'b0;
            busy_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            div_r    <= div_nxt;
            edges_r  <= edges_nxt;
            sclk_r   <= sclk_nxt;
            cs_n_r   <= cs_n_nxt;
            cal_r    <= cal_nxt;
            one_r    <= one_nxt;
            acc_a_r  <= acc_a_nxt;
            acc_b_r  <= acc_b_nxt;
            word_a_r <= word_a_nxt;
            word_b_r <= word_b_nxt;
            valid_r  <= valid_nxt;
            busy_r   <= busy_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign LINK.sclk    = sclk_r;
    assign LINK.cs_n    = cs_n_r;
    assign LINK.cal_req = cal_r;
    assign BUSY         = busy_r;
    assign WORD_A       = word_a_r;
    assign WORD_B       = word_b_r;
    assign WORD_VALID   = valid_r;

endmodule

// ==== hdl/dar_link_if.sv ====
// Serial link between the converter readout end and its host.
`timescale 1ns/10ps
interface dar_link_if;
    logic sclk;
    logic cs_n;
    logic cal_req;
    logic a_o;
    logic a_oe_n;
    logic b_o;
    logic b_oe_n;
    logic result_line_a;
    logic result_line_b;
    // Resolve the shared result lines; a released line reads high.
    assign result_line_a = a_o | a_oe_n;
    assign result_line_b = b_o | b_oe_n;
    modport dev (input sclk, input cs_n, input cal_req,
                 output a_o, output a_oe_n, output b_o, output b_oe_n);
    modport host (output sclk, output cs_n, output cal_req,
                  input result_line_a, input result_line_b);
endinterface

// ==== hdl/dar_pkg.sv ====
// Constants and types shared by both ends of the dual converter readout link.
package dar_pkg;
    localparam int RES_W = 12;
    localparam int CNT_W = 6;
    localparam int GAIN_W = 4;
    localparam int DIV_W = 2;
    // Falling clock edge numbers within a frame.
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] FALL_MSB = 6'h13;
    localparam logic [CNT_W-1:0] FALL_SECOND = 6'h1F;
    localparam logic [CNT_W-1:0] FALL_OFF = 6'h2B;
    localparam logic [CNT_W-1:0] HOST_FIRST = 6'h14;
    localparam logic [CNT_W-1:0] HOST_LAST = 6'h1F;
    localparam logic [CNT_W-1:0] HOST_LAST2 = 6'h2B;
    // Control word position of the calibration request bit.
    localparam int CTRL_CAL_BIT = 7;
    // Saturation limits for results and stored offsets.
    localparam logic signed [RES_W:0] SAT_HI = 13'sh07FF;
    localparam logic signed [RES_W:0] SAT_LO = 13'sh1800;
    localparam logic signed [RES_W-1:0] OFF_HI = 12'sh080;
    localparam logic signed [RES_W-1:0] OFF_LO = 12'shF80;
    localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
    // Request lead time before select falls, and its cycle count.
    localparam int CLK_PERIOD_NS = 100;
    localparam int CAL_LEAD_NS = 100;
    localparam int CAL_LEAD_CYC_I =
        (CAL_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CAL_LEAD_CYC = 4'(CAL_LEAD_CYC_I);
    // Host serial clock half period in core cycles, minus one.
    localparam logic [DIV_W-1:0] SCLK_HALF_M1 = 2'h1;
    typedef enum logic [1:0] {DEV_IDLE, DEV_CONV, DEV_SHIFT} dar_dev_type;
    typedef enum logic [1:0] {H_IDLE, H_FRAME, H_GAP} dar_host_type;
endpackage

// ==== testbench/dar_link_sva.sv ====
// Checker for the serial link between the converter and host ends.
`timescale 1ns/10ps
module dar_link_sva
    import dar_pkg::*;
(
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Link lines.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic cal_req,
    input wire logic a_o,
    input wire logic a_oe_n,
    input wire logic b_o,
    input wire logic b_oe_n
);
    logic             cs_q_r;
    logic             cs_q_nxt;
    logic             sck_q_r;
    logic             sck_q_nxt;
    logic [1:0]       fall_d_r;
    logic [1:0]       fall_d_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             cs_fall;
    logic             fall;
    logic             flt;
    // Counts clock falls per frame; a fall that meets the select fall is lost.
    always_comb begin
        cs_fall    = cs_q_r & ~cs_n;
        fall       = sck_q_r & ~sclk & ~cs_n & ~cs_fall;
        flt        = a_oe_n & b_oe_n;
        cs_q_nxt   = cs_n;
        sck_q_nxt  = sclk;
        fall_d_nxt = {fall_d_r[0], fall};
        cnt_nxt    = cnt_r;
        if (cs_fall) begin
            cnt_nxt = CNT_ZERO;
        end else if (fall && cnt_r != 6'h3F) begin
            cnt_nxt = cnt_r + CNT_ONE;
        end
    end
    // Registers the helper state; reset matches an idle link.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cs_q_r   <= 1'h1;
            sck_q_r  <= 1'h1;
            fall_d_r <= 2'h0;
            cnt_r    <= CNT_ZERO;
        end else begin
            cs_q_r   <= cs_q_nxt;
            sck_q_r  <= sck_q_nxt;
            fall_d_r <= fall_d_nxt;
            cnt_r    <= cnt_nxt;
        end
    end
    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    // Line enables and data tied to the fall count and the select edges, and request rises kept outside frames.
    AST_FLOAT_CONV: assert property (
        !cs_n && !cs_fall && cnt_r < FALL_MSB |-> flt)
        else $error("result line driven during conversion");
    AST_ENABLE_MSB: assert property (
        fall && cnt_r == 6'h12 |-> ##[1:2] (!a_oe_n && !b_oe_n))
        else $error("result lines not enabled at fall 19");
    AST_OE_PAIR: assert property (a_oe_n == b_oe_n)
        else $error("result line enables differ");
    AST_BIT_STEP: assert property (
        !cs_n && !a_oe_n && !$past(a_oe_n) && ($changed(a_o) ||
        $changed(b_o)) |-> fall_d_r != 2'h0)
        else $error("result bit changed without a clock fall");
    AST_STAND: assert property (
        !cs_n && !cs_fall && cnt_r >= 6'h14 && cnt_r <= 6'h2A |-> !a_oe_n)
        else $error("result line released inside the readout");
    AST_FLOAT_END: assert property (
        fall && cnt_r == 6'h2A |-> ##[1:2] flt)
        else $error("result lines not floated at fall 43");
    AST_FLOAT_RISE: assert property ($rose(cs_n) |-> ##[1:2] flt)
        else $error("result lines not floated after select rise");
    AST_CAL_QUIET: assert property ($rose(cal_req) |-> $past(cs_n))
        else $error("calibration request raised inside a frame");
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench joining the converter and host ends over the link.
`timescale 1ns/10ps
module tb_top;
    import dar_pkg::*;
    logic              clk, rst_n;
    logic              start = 1'h0, one_line = 1'h0, cal_want = 1'h0;
    logic              ctrl_wr = 1'h0;
    logic [GAIN_W-1:0] gain_sel = 4'h0;
    logic [RES_W-1:0]  raw_a = 12'h000, raw_b = 12'h000, ctrl_word = 12'h000;
    logic [RES_W-1:0]  word_a, word_b, off_a, off_b;
    logic              busy, word_valid, hold, shorted, cal_done, cal_inacc;
    logic              corrupt, gain_stale;
    logic [2:0]        seen = 3'h0;
    int                num_errors = 0;
    int                cmp_count = 0;
    dar_link_if u_dar_link_if ();
    // Both ends face each other; the checker watches the link between them.
    dar_device u_dar_device (.CORE_CLK(clk), .RST_N(rst_n),
        .LINK(u_dar_link_if), .RAW_A(raw_a), .RAW_B(raw_b),
        .GAIN_SEL(gain_sel), .CTRL_WORD(ctrl_word), .CTRL_WR(ctrl_wr),
        .HOLD(hold), .INPUTS_SHORTED(shorted), .CAL_DONE(cal_done),
        .CAL_INACCURATE(cal_inacc), .RESULT_CORRUPT(corrupt),
        .GAIN_STALE(gain_stale), .OFFSET_A(off_a), .OFFSET_B(off_b));
    dar_host u_dar_host (.CORE_CLK(clk), .RST_N(rst_n),
        .LINK(u_dar_link_if), .START(start), .ONE_LINE(one_line),
        .CAL_WANT(cal_want), .BUSY(busy), .WORD_A(word_a), .WORD_B(word_b),
        .WORD_VALID(word_valid));
    dar_link_sva u_dar_link_sva (.CORE_CLK(clk), .RST_N(rst_n),
        .sclk(u_dar_link_if.sclk), .cs_n(u_dar_link_if.cs_n),
        .cal_req(u_dar_link_if.cal_req), .a_o(u_dar_link_if.a_o),
        .a_oe_n(u_dar_link_if.a_oe_n), .b_o(u_dar_link_if.b_o),
        .b_oe_n(u_dar_link_if.b_oe_n));
    // Makes the 10 MHz core clock.
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [RES_W-1:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Runs one frame and gathers hold, shorted and done as seen.
    task automatic frame(input logic one, input logic [RES_W-1:0] ra, rb);
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        raw_a = ra;
        raw_b = rb;
        one_line = one;
        start = 1'h1;
        seen = 3'h0;
        @(negedge clk);
        start = 1'h0;
        n = 0;
        while (word_valid !== 1'h1 && n < 400) begin
            @(negedge clk);
            seen = seen | {hold, shorted, cal_done};
            n++;
        end
        chk(12'(word_valid), 12'h001);
    endtask
    // Plain readout on both lines straight after reset.
    task automatic t_plain;
        frame(1'h0, 12'h5A3, 12'h9C1);
        chk(word_a, 12'h5A3);
        chk(word_b, 12'h9C1);
        chk(12'(seen), 12'h004);
        chk(12'(hold), 12'h000);
        chk(off_a, RES_ZERO);
        $display("test done: two line readout");
    endtask
    // Both words on one line, then a normal frame right after it.
    task automatic t_one;
        frame(1'h1, 12'h0F0, 12'hA5A);
        chk(word_a, 12'h0F0);
        chk(word_b, 12'hA5A);
        frame(1'h0, 12'h001, 12'hFFE);
        chk(word_b, 12'hFFE);
        $display("test done: one line readout");
    endtask
    // Calibration by the request pin, held over two frames, then released.
    task automatic t_cal;
        @(negedge clk);
        cal_want = 1'h1;
        repeat (3) @(negedge clk);
        frame(1'h0, 12'h010, 12'hFF0);
        chk(12'(seen), 12'h007);
        chk(off_a, 12'h010);
        chk(off_b, 12'hFF0);
        chk(12'(cal_inacc), 12'h000);
        frame(1'h0, 12'h0C8, 12'hF00);
        chk(off_a, 12'h080);
        chk(off_b, 12'hF80);
        chk(word_a, 12'h0B8);
        chk(word_b, 12'hF10);
        cal_want = 1'h0;
        repeat (2) @(negedge clk);
        frame(1'h0, 12'h800, 12'h7FF);
        chk(12'(seen), 12'h004);
        chk(word_a, 12'h800);
        chk(word_b, 12'h7FF);
        $display("test done: pin calibration");
    endtask
    // Control word calibration, with a write that spoils a conversion.
    task automatic t_ctrl;
        @(negedge clk);
        ctrl_word = 12'hF70;
        ctrl_wr = 1'h1;
        @(negedge clk);
        ctrl_wr = 1'h0;
        frame(1'h0, 12'h123, 12'h321);
        chk(12'(seen), 12'h004);
        chk(word_a, 12'h0A3);
        chk(word_b, 12'h3A1);
        fork
            frame(1'h0, 12'h200, 12'h200);
            begin
                repeat (8) @(negedge clk);
                ctrl_word = 12'h080;
                ctrl_wr = 1'h1;
                @(negedge clk);
                ctrl_wr = 1'h0;
            end
        join
        chk(12'(corrupt), 12'h001);
        frame(1'h0, 12'h004, 12'hFFC);
        chk(12'(seen), 12'h007);
        chk(off_a, 12'h004);
        chk(off_b, 12'hFFC);
        chk(word_a, 12'hF84);
        chk(word_b, 12'h07C);
        chk(12'(corrupt), 12'h000);
        $display("test done: control word calibration");
    endtask
    // A gain change keeps old offsets; then a late request calibrates.
    task automatic t_gain;
        chk(12'(gain_stale), 12'h000);
        @(negedge clk);
        gain_sel = 4'h3;
        frame(1'h0, 12'h100, 12'h100);
        chk(12'(gain_stale), 12'h001);
        chk(word_a, 12'h0FC);
        chk(word_b, 12'h104);
        // The request rises with the select fall, too late to settle.
        fork
            frame(1'h0, 12'h020, 12'hFE0);
            begin
                @(negedge clk);
                cal_want = 1'h1;
            end
        join
        chk(12'(cal_inacc), 12'h001);
        frame(1'h0, 12'h010, 12'h010);
        chk(12'(cal_inacc), 12'h000);
        chk(12'(gain_stale), 12'h000);
        chk(off_b, 12'h010);
        chk(word_a, 12'hFF0);
        cal_want = 1'h0;
        $display("test done: gain change");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cuts a hang short well after the tests should have ended.
    initial begin
        repeat (10000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    // Resets for six cycles, then runs every test in turn.
    initial begin
        rst_n = 1'h0;
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        t_plain();
        t_one();
        t_cal();
        t_ctrl();
        t_gain();
        complete_run();
    end
endmodule
